// ==== include/sfc_pkg.sv ====
package sfc_pkg;
  localparam logic [2:0] LN1 = 3'h1;
  localparam logic [2:0] LN2 = 3'h2;
  localparam logic [2:0] LN4 = 3'h4;
  localparam int ADDR_KEEP = 22;
  localparam logic [4:0] ADDR_BITS = 5'h18;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [8:0] PAGE_BYTES = 9'h100;
  localparam logic [3:0] DUMMY_FAST = 4'h8;
  localparam logic [3:0] DUMMY_DIO = 4'h4;
  localparam logic [3:0] DUMMY_QIO = 4'h6;
  localparam int SCLK_HALF_CYC = 3;
  localparam int RD_BUF_DEPTH = 2;
  localparam logic [7:0] OP_RD = 8'h03;
  localparam logic [7:0] OP_FRD = 8'h0B;
  localparam logic [7:0] OP_DOR = 8'h3B;
  localparam logic [7:0] OP_DIO = 8'hBB;
  localparam logic [7:0] OP_QOR = 8'h6B;
  localparam logic [7:0] OP_QIO = 8'hEB;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_QPP = 8'h32;
  localparam logic [7:0] OP_BE4 = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE64 = 8'hD8;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_CE = 8'hC7;
  localparam logic [7:0] OP_CE2 = 8'h60;

  typedef enum logic [1:0] {
    SFC_DIR_NONE = 2'h0,
    SFC_DIR_RD = 2'h1,
    SFC_DIR_WR = 2'h2
  } sfc_dir_t;

  typedef struct packed {
    logic known;
    logic has_addr;
    logic [2:0] alanes;
    logic [2:0] dlanes;
    sfc_dir_t dir;
    logic [3:0] dummy;
  } sfc_cls_t;

  // -----------------------------------------------
  // opcode classes
  // -----------------------------------------------
  function automatic sfc_cls_t sfc_decode(input logic [7:0] op);
    sfc_cls_t c;
    c = '{1'b1, 1'b1, LN1, LN1, SFC_DIR_RD, 4'h0};
    unique case (op)
      OP_RD: c.dummy = 4'h0;
      OP_FRD: c.dummy = DUMMY_FAST;
      OP_DOR: begin
        c.dlanes = LN2;
        c.dummy = DUMMY_FAST;
      end
      OP_DIO: begin
        c.alanes = LN2;
        c.dlanes = LN2;
        c.dummy = DUMMY_DIO;
      end
      OP_QOR: begin
        c.dlanes = LN4;
        c.dummy = DUMMY_FAST;
      end
      OP_QIO: begin
        c.alanes = LN4;
        c.dlanes = LN4;
        c.dummy = DUMMY_QIO;
      end
      OP_PP: c.dir = SFC_DIR_WR;
      OP_QPP: begin
        c.dir = SFC_DIR_WR;
        c.dlanes = LN4;
      end
      OP_BE4, OP_BE32, OP_BE64: c.dir = SFC_DIR_NONE;
      OP_WREN, OP_WRDI, OP_CE, OP_CE2: begin
        c.dir = SFC_DIR_NONE;
        c.has_addr = 1'b0;
      end
      default: c.known = 1'b0;
    endcase
    return c;
  endfunction

  // -----------------------------------------------
  // lane mapping; so selects lane 1 for one-lane use
  // -----------------------------------------------
  function automatic logic [3:0] sfc_spread(input logic [3:0] top, input logic [2:0] ln,
                                            input logic so);
    if (ln == LN4) return top;
    if (ln == LN2) return {2'h0, top[3:2]};
    return so ? {2'h0, top[3], 1'b0} : {3'h0, top[3]};
  endfunction

  function automatic logic [3:0] sfc_mask(input logic [2:0] ln, input logic so);
    return sfc_spread(4'hF, ln, so);
  endfunction

  function automatic logic [23:0] sfc_shift_in(input logic [23:0] sr, input logic [3:0] dq,
                                               input logic [2:0] ln, input logic so);
    if (ln == LN4) return {sr[19:0], dq};
    if (ln == LN2) return {sr[21:0], dq[1:0]};
    return {sr[22:0], so ? dq[1] : dq[0]};
  endfunction
endpackage

// ==== include/sfc_link_if.sv ====
`timescale 1ns/1ps
interface sfc_link_if;
  logic sclk;
  logic cs_n;
  logic [3:0] h_dq;
  logic [3:0] h_oe;
  logic [3:0] d_dq;
  logic [3:0] d_oe;
  logic [3:0] dq;

  // resolved lanes; undriven lanes read high (pull-up)
  assign dq = (d_oe & d_dq) | (~d_oe & h_oe & h_dq) | (~d_oe & ~h_oe);

  modport host (output sclk, output cs_n, output h_dq, output h_oe, input dq);
  modport dev (input sclk, input cs_n, input dq, output d_dq, output d_oe);
endinterface

// ==== hw/sfc_buf.sv ====
`timescale 1ns/1ps
module sfc_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [W-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  wire logic push = in_valid_i & in_ready_o;
  wire logic pop = out_valid_o & out_ready_i;
  wire logic [CW-1:0] cnt_nxt = cnt_r + CW'(push) - CW'(pop);

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign out_data_o = mem[rp_r];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      in_ready_o <= 1'b0;
      out_valid_o <= 1'b0;
    end else begin
      wp_r <= push ? bump(wp_r) : wp_r;
      rp_r <= pop ? bump(rp_r) : rp_r;
      cnt_r <= cnt_nxt;
      in_ready_o <= cnt_nxt != CW'(DEPTH);
      out_valid_o <= cnt_nxt != '0;
    end
  end
endmodule

// ==== hw/sfc_dev.sv ====
`timescale 1ns/1ps
module sfc_dev (
  sfc_link_if.dev lk,
  input wire logic clk_i,
  input wire logic rst_i,
  output logic cmd_valid_o,
  output logic [7:0] cmd_op_o,
  output logic [sfc_pkg::ADDR_KEEP-1:0] cmd_addr_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic [7:0] rx_col_o,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_valid_i,
  output logic rd_ready_o
);
  typedef enum logic [5:0] {
    SFC_D_OPC = 6'h01,
    SFC_D_ADR = 6'h02,
    SFC_D_DUM = 6'h04,
    SFC_D_DIN = 6'h08,
    SFC_D_OUT = 6'h10,
    SFC_D_IGN = 6'h20
  } sfc_dst_t;

  // -----------------------------------------------
  // link side, serial clock domain
  // -----------------------------------------------
  sfc_dst_t st_r;
  sfc_dst_t st_nxt;
  logic [23:0] sr_r;
  logic [4:0] bcnt_r;
  logic [4:0] bcnt_nxt;
  sfc_pkg::sfc_cls_t cls_r;
  logic [7:0] out_sr_r;
  logic [4:0] orem_r;
  logic [3:0] d_dq_r;
  logic [3:0] d_oe_r;
  logic cmd_tgl_r;
  logic rx_tgl_r;
  logic req_tgl_r;
  logic [7:0] cap_op_r;
  logic [sfc_pkg::ADDR_KEEP-1:0] cap_addr_r;
  logic [7:0] rx_byte_r;
  logic [7:0] col_r;
  logic [7:0] cap_col_r;
  logic [7:0] rd_hold_r;

  wire logic [2:0] lanes_in = (st_r == SFC_D_ADR) ? cls_r.alanes :
                              (st_r == SFC_D_DIN) ? cls_r.dlanes : sfc_pkg::LN1;
  wire logic [23:0] sr_in = sfc_pkg::sfc_shift_in(sr_r, lk.dq, lanes_in, 1'b0);
  wire logic [4:0] bsum = bcnt_r + {2'h0, lanes_in};
  wire sfc_pkg::sfc_cls_t cls_new = sfc_pkg::sfc_decode(sr_in[7:0]);
  wire logic opc_done = (st_r == SFC_D_OPC) && (bsum == sfc_pkg::BYTE_BITS);
  wire logic adr_done = (st_r == SFC_D_ADR) && (bsum == sfc_pkg::ADDR_BITS);
  wire logic dum_done = (st_r == SFC_D_DUM) && (bsum == {1'b0, cls_r.dummy});
  wire logic byte_done = (st_r == SFC_D_DIN) && (bsum == sfc_pkg::BYTE_BITS);
  wire logic cmd_done = (opc_done & cls_new.known & ~cls_new.has_addr) | adr_done;
  wire logic out_load = (st_r == SFC_D_OUT) && (orem_r == 5'h00);
  wire logic [7:0] ob = out_load ? rd_hold_r : out_sr_r;

  function automatic sfc_dst_t data_phase(input sfc_pkg::sfc_cls_t c);
    if (c.dir == sfc_pkg::SFC_DIR_RD) return SFC_D_OUT;
    if (c.dir == sfc_pkg::SFC_DIR_WR) return SFC_D_DIN;
    return SFC_D_IGN;
  endfunction

  function automatic sfc_dst_t after_addr(input sfc_pkg::sfc_cls_t c);
    return (c.dummy != 4'h0) ? SFC_D_DUM : data_phase(c);
  endfunction

  always_comb begin
    st_nxt = st_r;
    bcnt_nxt = bsum;
    unique case (st_r)
      SFC_D_OPC: begin
        if (opc_done) begin
          bcnt_nxt = 5'h00;
          if (!cls_new.known) begin
            st_nxt = SFC_D_IGN;
          end else if (cls_new.has_addr) begin
            st_nxt = SFC_D_ADR;
          end else begin
            st_nxt = after_addr(cls_new);
          end
        end
      end
      SFC_D_ADR: begin
        if (adr_done) begin
          bcnt_nxt = 5'h00;
          st_nxt = after_addr(cls_r);
        end
      end
      SFC_D_DUM: begin
        if (dum_done) begin
          bcnt_nxt = 5'h00;
          st_nxt = data_phase(cls_r);
        end
      end
      SFC_D_DIN: begin
        if (byte_done) begin
          bcnt_nxt = 5'h00;
        end
      end
      SFC_D_OUT, SFC_D_IGN: bcnt_nxt = 5'h00;
    endcase
  end

  // select release clears the command at once
  always_ff @(posedge lk.sclk or posedge lk.cs_n) begin
    if (lk.cs_n) begin
      st_r <= SFC_D_OPC;
      bcnt_r <= 5'h00;
      sr_r <= 24'h00_0000;
      cls_r <= '0;
    end else begin
      st_r <= st_nxt;
      bcnt_r <= bcnt_nxt;
      sr_r <= sr_in;
      if (opc_done) begin
        cls_r <= cls_new;
      end
    end
  end

  // events to the system side; kept over frames
  always_ff @(posedge lk.sclk or posedge rst_i) begin
    if (rst_i) begin
      cmd_tgl_r <= 1'b0;
      rx_tgl_r <= 1'b0;
      cap_op_r <= 8'h00;
      cap_addr_r <= '0;
      rx_byte_r <= 8'h00;
      col_r <= 8'h00;
      cap_col_r <= 8'h00;
    end else begin
      if (cmd_done) begin
        cmd_tgl_r <= ~cmd_tgl_r;
      end
      if (opc_done) begin
        cap_op_r <= sr_in[7:0];
        cap_addr_r <= '0;
      end
      if (adr_done) begin
        cap_addr_r <= sr_in[sfc_pkg::ADDR_KEEP-1:0];
        col_r <= sr_in[7:0];
      end
      if (byte_done) begin
        rx_tgl_r <= ~rx_tgl_r;
        rx_byte_r <= sr_in[7:0];
        cap_col_r <= col_r;
        col_r <= col_r + 8'h01;
      end
    end
  end

  // output lanes change on the falling edge
  always_ff @(negedge lk.sclk or posedge lk.cs_n) begin
    if (lk.cs_n) begin
      out_sr_r <= 8'h00;
      orem_r <= 5'h00;
      d_dq_r <= 4'h0;
      d_oe_r <= 4'h0;
    end else if (st_r == SFC_D_OUT) begin
      d_dq_r <= sfc_pkg::sfc_spread(ob[7:4], cls_r.dlanes, 1'b1);
      d_oe_r <= sfc_pkg::sfc_mask(cls_r.dlanes, 1'b1);
      out_sr_r <= 8'(ob << cls_r.dlanes);
      orem_r <= (out_load ? sfc_pkg::BYTE_BITS : orem_r) - {2'h0, cls_r.dlanes};
    end else begin
      d_oe_r <= 4'h0;
    end
  end

  always_ff @(negedge lk.sclk or posedge rst_i) begin
    if (rst_i) begin
      req_tgl_r <= 1'b0;
    end else if (out_load) begin
      req_tgl_r <= ~req_tgl_r;
    end
  end

  assign lk.d_dq = d_dq_r;
  assign lk.d_oe = d_oe_r;

  // -----------------------------------------------
  // system side, clk_i domain
  // -----------------------------------------------
  logic [2:0] sy1_r;
  logic [2:0] sy2_r;
  logic [2:0] sy3_r;
  logic hold_full_r;
  logic [7:0] bq_data;
  logic bq_valid;
  wire logic [2:0] ev = sy2_r ^ sy3_r;
  wire logic bq_pop = bq_valid & ~hold_full_r;

  sfc_buf #(
    .W(8),
    .DEPTH(sfc_pkg::RD_BUF_DEPTH)
  ) u_rd_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_data_i(rd_data_i),
    .in_valid_i(rd_valid_i),
    .in_ready_o(rd_ready_o),
    .out_data_o(bq_data),
    .out_valid_o(bq_valid),
    .out_ready_i(bq_pop)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sy1_r <= 3'h0;
      sy2_r <= 3'h0;
      sy3_r <= 3'h0;
      hold_full_r <= 1'b0;
      rd_hold_r <= 8'h00;
      cmd_valid_o <= 1'b0;
      cmd_op_o <= 8'h00;
      cmd_addr_o <= '0;
      rx_valid_o <= 1'b0;
      rx_data_o <= 8'h00;
      rx_col_o <= 8'h00;
    end else begin
      sy1_r <= {req_tgl_r, rx_tgl_r, cmd_tgl_r};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
      cmd_valid_o <= ev[0];
      rx_valid_o <= ev[1];
      if (ev[0]) begin
        cmd_op_o <= cap_op_r;
        cmd_addr_o <= cap_addr_r;
      end
      if (ev[1]) begin
        rx_data_o <= rx_byte_r;
        rx_col_o <= cap_col_r;
      end
      // link took the held byte; refill from buffer
      if (bq_pop) begin
        rd_hold_r <= bq_data;
        hold_full_r <= 1'b1;
      end else if (ev[2]) begin
        hold_full_r <= 1'b0;
      end
    end
  end
endmodule

// ==== hw/sfc_host.sv ====
`timescale 1ns/1ps
module sfc_host #(
  parameter int HALF = sfc_pkg::SCLK_HALF_CYC
) (
  sfc_link_if.host lk,
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [7:0] op_i,
  input wire logic [23:0] addr_i,
  input wire logic [8:0] len_i,
  output logic busy_o,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o
);
  typedef enum logic [6:0] {
    SFC_H_IDLE = 7'h01,
    SFC_H_OPC = 7'h02,
    SFC_H_ADR = 7'h04,
    SFC_H_DUM = 7'h08,
    SFC_H_WR = 7'h10,
    SFC_H_RD = 7'h20,
    SFC_H_END = 7'h40
  } sfc_hst_t;

  sfc_hst_t st_r;
  sfc_hst_t nst;
  sfc_pkg::sfc_cls_t cls_r;
  logic [7:0] div_r;
  logic sclk_r;
  logic cs_n_r;
  logic [23:0] sr_r;
  logic [23:0] nsr;
  logic [4:0] rem_r;
  logic [4:0] nrem;
  logic [23:0] addr_r;
  logic [8:0] len_r;
  logic [8:0] nbyte_r;
  logic [23:0] rcv_r;
  logic [3:0] dq_r;
  logic [3:0] oe_r;
  logic [3:0] dq_s1_r;
  logic [3:0] dq_s2_r;
  logic take_wr;

  function automatic logic [2:0] lanes_of(input sfc_hst_t s, input sfc_pkg::sfc_cls_t c);
    if (s == SFC_H_ADR) return c.alanes;
    if (s == SFC_H_WR || s == SFC_H_RD) return c.dlanes;
    return sfc_pkg::LN1;
  endfunction

  wire sfc_pkg::sfc_cls_t cls_i = sfc_pkg::sfc_decode(op_i);
  wire logic [2:0] ln = lanes_of(st_r, cls_r);
  wire logic [2:0] nln = lanes_of(nst, cls_r);
  wire logic [4:0] rem_sub = rem_r - {2'h0, ln};
  wire logic tick = div_r == 8'(HALF - 1);
  wire logic run = (st_r != SFC_H_IDLE) && (st_r != SFC_H_END);
  wire logic rise = tick & ~sclk_r & run;
  wire logic fall = tick & sclk_r;
  wire logic fall_go = fall & ~(take_wr & ~wr_valid_i);
  wire logic last_byte = (nbyte_r + 9'h001) >= len_r;
  wire logic [23:0] rcv_in = sfc_pkg::sfc_shift_in(rcv_r, dq_s2_r, ln, 1'b1);
  wire logic drives = (nst == SFC_H_OPC) || (nst == SFC_H_ADR) || (nst == SFC_H_WR);

  // next phase at a falling edge
  always_comb begin
    nst = st_r;
    nrem = rem_sub;
    nsr = 24'(sr_r << ln);
    take_wr = 1'b0;
    if (rem_sub == 5'h00) begin
      if (st_r == SFC_H_OPC && cls_r.known && cls_r.has_addr) begin
        nst = SFC_H_ADR;
        nrem = sfc_pkg::ADDR_BITS;
        nsr = addr_r;
      end else if (st_r == SFC_H_OPC && !cls_r.known) begin
        nst = SFC_H_END;
      end else if ((st_r == SFC_H_OPC || st_r == SFC_H_ADR) && cls_r.dummy != 4'h0) begin
        nst = SFC_H_DUM;
        nrem = {1'b0, cls_r.dummy};
      end else if ((st_r == SFC_H_WR || st_r == SFC_H_RD) && last_byte) begin
        nst = SFC_H_END;
      end else if (cls_r.dir == sfc_pkg::SFC_DIR_RD) begin
        nst = SFC_H_RD;
        nrem = sfc_pkg::BYTE_BITS;
      end else if (cls_r.dir == sfc_pkg::SFC_DIR_WR && len_r != 9'h000) begin
        nst = SFC_H_WR;
        nrem = sfc_pkg::BYTE_BITS;
        nsr = {wr_data_i, 16'h0000};
        take_wr = 1'b1;
      end else begin
        nst = SFC_H_END;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dq_s1_r <= 4'h0;
      dq_s2_r <= 4'h0;
    end else begin
      dq_s1_r <= lk.dq;
      dq_s2_r <= dq_s1_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= SFC_H_IDLE;
      cls_r <= '0;
      div_r <= 8'h00;
      sclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      sr_r <= 24'h00_0000;
      rem_r <= 5'h00;
      addr_r <= 24'h00_0000;
      len_r <= 9'h000;
      nbyte_r <= 9'h000;
      rcv_r <= 24'h00_0000;
      dq_r <= 4'h0;
      oe_r <= 4'h0;
      busy_o <= 1'b0;
      wr_ready_o <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o <= 8'h00;
    end else begin
      wr_ready_o <= fall_go & take_wr;
      rd_valid_o <= 1'b0;
      div_r <= (st_r == SFC_H_IDLE || (tick && !(fall && !fall_go))) ? 8'h00 :
               (tick ? div_r : div_r + 8'h01);
      if (st_r == SFC_H_IDLE && start_i) begin
        st_r <= SFC_H_OPC;
        cls_r <= cls_i;
        cs_n_r <= 1'b0;
        sr_r <= {op_i, 16'h0000};
        rem_r <= sfc_pkg::BYTE_BITS;
        addr_r <= addr_i;
        len_r <= (cls_i.dir == sfc_pkg::SFC_DIR_WR && len_i > sfc_pkg::PAGE_BYTES) ?
                 sfc_pkg::PAGE_BYTES : len_i;
        nbyte_r <= 9'h000;
        dq_r <= sfc_pkg::sfc_spread(op_i[7:4], sfc_pkg::LN1, 1'b0);
        oe_r <= sfc_pkg::sfc_mask(sfc_pkg::LN1, 1'b0);
        busy_o <= 1'b1;
      end else if (st_r == SFC_H_END && tick) begin
        st_r <= SFC_H_IDLE;
        cs_n_r <= 1'b1;
        busy_o <= 1'b0;
      end
      if (rise) begin
        sclk_r <= 1'b1;
        if (st_r == SFC_H_RD) begin
          rcv_r <= rcv_in;
          if (rem_r == {2'h0, ln}) begin
            rd_valid_o <= 1'b1;
            rd_data_o <= rcv_in[7:0];
          end
        end
      end
      if (fall_go) begin
        sclk_r <= 1'b0;
        st_r <= nst;
        rem_r <= nrem;
        sr_r <= nsr;
        dq_r <= sfc_pkg::sfc_spread(nsr[23:20], nln, 1'b0);
        oe_r <= drives ? sfc_pkg::sfc_mask(nln, 1'b0) : 4'h0;
        if ((st_r == SFC_H_WR || st_r == SFC_H_RD) && rem_sub == 5'h00) begin
          nbyte_r <= nbyte_r + 9'h001;
        end
      end
    end
  end

  assign lk.sclk = sclk_r;
  assign lk.cs_n = cs_n_r;
  assign lk.h_dq = dq_r;
  assign lk.h_oe = oe_r;
endmodule

// ==== verif/sfc_link_properties.sv ====
`timescale 1ns/1ps
module sfc_link_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] h_dq,
  input wire logic [3:0] h_oe,
  input wire logic [3:0] d_dq,
  input wire logic [3:0] d_oe
);
  // -----------------------------------------------
  // sclk rises seen in the current frame
  // -----------------------------------------------
  logic sclk_r;
  logic [5:0] rise_r;
  logic [5:0] rise_nxt;
  wire rise_now = sclk && !sclk_r && (rise_r != 6'h3F);
  assign rise_nxt = cs_n ? 6'h00 : (rise_now ? rise_r + 6'h01 : rise_r);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_r <= 1'b0;
      rise_r <= 6'h00;
    end else begin
      sclk_r <= sclk;
      rise_r <= rise_nxt;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // -----------------------------------------------
  // frame opening, then lane, clock and phase checks
  // -----------------------------------------------
  sequence s_open;
    $fell(cs_n) ##0 !sclk;
  endsequence
  sequence s_first_rise;
    ##[1:8] $rose(sclk);
  endsequence

  a_frame_first_edge: assert property (s_open |-> s_first_rise)
    else $error("serial clock did not start after select");
  a_lanes_released: assert property (cs_n |-> d_oe == 4'h0)
    else $error("device drives a lane while deselected");
  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("serial clock not low between frames");
  a_no_contention: assert property ((d_oe & h_oe) == 4'h0)
    else $error("host and device drive the same lane");
  a_host_rise_stable: assert property ($rose(sclk) && !cs_n |-> $stable(h_dq) && $stable(h_oe))
    else $error("host lanes changed on a rising edge");
  a_dev_fall_only: assert property (!cs_n && !$past(cs_n) && $changed(d_dq) |-> $fell(sclk))
    else $error("device lanes changed away from a falling edge");
  a_dev_lane_set: assert property (d_oe == 4'h0 || d_oe == 4'h2 || d_oe == 4'h3 || d_oe == 4'hF)
    else $error("device output enables form no legal lane set");
  a_opcode_one_lane: assert property (!cs_n && rise_r < 6'h08 |-> h_oe == 4'h1)
    else $error("opcode not on lane 0 alone");
  a_early_quiet: assert property (!cs_n && rise_r < 6'h14 |-> d_oe == 4'h0)
    else $error("device drove lanes before address and dummy ended");
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/1ps
module tb;
  typedef struct {
    logic [7:0] op;
    logic [23:0] addr;
    int len;
    int ncmd;
    int nrd;
    int nrx;
  } sfc_row_t;
  logic clk_i, rst_i, start_i, busy_o, wr_valid_i, wr_ready_o, rd_valid_o;
  logic [7:0] op_i, wr_data_i, rd_data_o, rd_data_i, rx_data_o, rx_col_o, cmd_op_o, b_op;
  logic [23:0] addr_i, cur_addr;
  logic [8:0] len_i;
  logic cmd_valid_o, rx_valid_o, rd_ready_o, dev_rd_valid_i, b_cmd_valid;
  logic [21:0] cmd_addr_o, b_addr, b_cmd_addr;
  logic [7:0] cur_op, last_rd, b_cmd_op;
  int n_fail, checked, n_cmd, n_rd, n_rx, nb_cmd, wr_idx, gap;
  sfc_row_t rows [17] = '{
    '{8'h03, 24'hC1_2345, 3, 1, 3, 0}, '{8'h0B, 24'h00_10F0, 2, 1, 2, 0},
    '{8'h3B, 24'h80_0001, 3, 1, 3, 0}, '{8'hBB, 24'h3F_FFFF, 3, 1, 3, 0},
    '{8'h6B, 24'h40_0100, 4, 1, 4, 0}, '{8'hEB, 24'h12_3456, 4, 1, 4, 0},
    '{8'h02, 24'h3F_FFFE, 4, 1, 0, 4}, '{8'h32, 24'h00_01FF, 3, 1, 0, 3},
    '{8'h02, 24'h00_0A80, 256, 1, 0, 256}, '{8'h20, 24'hFF_F000, 0, 1, 0, 0},
    '{8'h52, 24'h2A_8000, 0, 1, 0, 0}, '{8'hD8, 24'h15_0000, 0, 1, 0, 0},
    '{8'h06, 24'h00_0000, 0, 1, 0, 0}, '{8'h04, 24'h00_0000, 0, 1, 0, 0},
    '{8'hC7, 24'h00_0000, 0, 1, 0, 0}, '{8'h60, 24'h00_0000, 0, 1, 0, 0},
    '{8'h9F, 24'h00_0000, 2, 0, 0, 0}};

  sfc_link_if lk ();
  sfc_link_if lk_b ();

  sfc_host i_sfc_host (.lk(lk), .clk_i(clk_i), .rst_i(rst_i), .start_i(start_i), .op_i(op_i),
    .addr_i(addr_i), .len_i(len_i), .busy_o(busy_o), .wr_data_i(wr_data_i),
    .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o));
  sfc_dev i_sfc_dev (.lk(lk), .clk_i(clk_i), .rst_i(rst_i), .cmd_valid_o(cmd_valid_o),
    .cmd_op_o(cmd_op_o), .cmd_addr_o(cmd_addr_o), .rx_valid_o(rx_valid_o),
    .rx_data_o(rx_data_o), .rx_col_o(rx_col_o), .rd_data_i(rd_data_i),
    .rd_valid_i(dev_rd_valid_i), .rd_ready_o(rd_ready_o));
  sfc_dev i_sfc_dev_b (.lk(lk_b), .clk_i(clk_i), .rst_i(rst_i), .cmd_valid_o(b_cmd_valid),
    .cmd_op_o(b_cmd_op), .cmd_addr_o(b_cmd_addr), .rx_valid_o(), .rx_data_o(), .rx_col_o(),
    .rd_data_i(8'h00), .rd_valid_i(1'b0), .rd_ready_o());
  sfc_link_properties i_sfc_link_properties (.clk_i(clk_i), .rst_i(rst_i), .sclk(lk.sclk),
    .cs_n(lk.cs_n), .h_dq(lk.h_dq), .h_oe(lk.h_oe), .d_dq(lk.d_dq), .d_oe(lk.d_oe));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // -----------------------------------------------
  // compare and closing
  // -----------------------------------------------
  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    checked++;
    if (got != exp) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checked %0d failed %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [7:0] wpat(input int i);
    return 8'(i) * 8'h25 + 8'h5A;
  endfunction

  // -----------------------------------------------
  // user-side feeders and monitors
  // -----------------------------------------------
  always @(posedge clk_i) begin
    dev_rd_valid_i <= !rst_i;
    if (rst_i) rd_data_i <= 8'h00;
    else if (dev_rd_valid_i && rd_ready_o) rd_data_i <= rd_data_i + 8'h01;
    wr_data_i <= wpat(wr_idx);
    if (start_i) wr_idx <= 0;
    else if (wr_ready_o) wr_idx <= wr_idx + 1;
    if (rst_i || wr_ready_o) begin
      wr_valid_i <= 1'b0;
      gap <= 30;
    end else if (gap != 0) gap <= gap - 1;
    else wr_valid_i <= 1'b1;
  end
  always @(posedge clk_i) begin
    if (cmd_valid_o) begin
      n_cmd++;
      chk_val(24'(cmd_op_o), 24'(cur_op));
      if (!(cur_op inside {8'h06, 8'h04, 8'hC7, 8'h60}))
        chk_val(24'(cmd_addr_o), 24'(cur_addr[21:0]));
    end
    if (rx_valid_o) begin
      chk_val(24'(rx_data_o), 24'(wpat(n_rx)));
      chk_val(24'(rx_col_o), 24'(8'(cur_addr[7:0] + 8'(n_rx))));
      n_rx++;
    end
    if (rd_valid_o) begin
      if (n_rd > 0) chk_val(24'(rd_data_o), 24'(8'(last_rd + 8'h01)));
      last_rd = rd_data_o;
      n_rd++;
    end
    if (b_cmd_valid) begin
      nb_cmd++;
      b_op = b_cmd_op;
      b_addr = b_cmd_addr;
    end
  end

  // -----------------------------------------------
  // tasks: one host command, one hand-made frame
  // -----------------------------------------------
  task automatic run_row(input sfc_row_t r);
    int k;
    cur_op = r.op;
    cur_addr = r.addr;
    n_cmd = 0;
    n_rd = 0;
    n_rx = 0;
    k = 0;
    @(posedge clk_i);
    start_i <= 1'b1;
    op_i <= r.op;
    addr_i <= r.addr;
    len_i <= 9'(r.len);
    @(posedge clk_i);
    start_i <= 1'b0;
    do begin
      @(posedge clk_i);
      k++;
    end while (busy_o !== 1'b0 && k < 40000);
    repeat (12) @(posedge clk_i);
    chk_cnt(int'(k < 40000), 1);
    chk_cnt(n_cmd, r.ncmd);
    chk_cnt(n_rd, r.nrd);
    chk_cnt(n_rx, r.nrx);
  endtask
  task automatic bb_frame(input logic [31:0] v, input int n, input int exp_n,
                          input logic [21:0] exp_addr);
    #7.3 lk_b.cs_n = 1'b0;
    lk_b.h_oe = 4'h1;
    for (int i = n - 1; i >= 0; i--) begin
      lk_b.h_dq[0] = v[i];
      #15 lk_b.sclk = 1'b1;
      #15 lk_b.sclk = 1'b0;
    end
    #20 lk_b.cs_n = 1'b1;
    lk_b.h_oe = 4'h0;
    repeat (20) @(posedge clk_i);
    chk_cnt(nb_cmd, exp_n);
    if (exp_n > 0) chk_val(24'(b_addr), 24'(exp_addr));
    $display("frame %h bits %0d done", v, n);
  endtask

  // -----------------------------------------------
  // main sequence
  // -----------------------------------------------
  initial begin
    rst_i = 1'b1;
    start_i = 1'b0;
    op_i = 8'h00;
    addr_i = 24'h00_0000;
    len_i = 9'h000;
    wr_data_i = 8'h00;
    wr_valid_i = 1'b0;
    rd_data_i = 8'h00;
    dev_rd_valid_i = 1'b0;
    lk_b.sclk = 1'b0;
    lk_b.cs_n = 1'b1;
    lk_b.h_dq = 4'h0;
    lk_b.h_oe = 4'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    chk_val(24'(lk.cs_n), 24'h00_0001);
    chk_val(24'(lk.sclk), 24'h00_0000);
    chk_val(24'(busy_o), 24'h00_0000);
    chk_val(24'(lk.d_oe), 24'h00_0000);
    chk_val(24'(rd_ready_o), 24'h00_0000);
    $display("test reset done");
    for (int i = 0; i < 17; i++) begin
      run_row(rows[i]);
      $display("test op %h len %0d done", rows[i].op, rows[i].len);
    end
    bb_frame({8'h9F, 8'h20, 16'h1234}, 32, 0, 22'h00_0000);
    bb_frame({8'h20, 24'hC0_0ABC}, 32, 1, 22'h00_0ABC);
    bb_frame({8'h00, 8'h52, 16'h1234}, 24, 1, 22'h00_0ABC);
    bb_frame({8'h52, 24'h3F_00FF}, 32, 2, 22'h3F_00FF);
    chk_val(24'(b_op), 24'h00_0052);
    report_and_stop();
  end

  initial begin
    #600_000;
    n_fail++;
    report_and_stop();
  end
endmodule
